// *** src/lid_regs.svh ***
// Offsets, field positions and reset values of the logon descriptor parser.
// Assumes inclusion by the parser and by the bench that decodes its map.
`ifndef LID_REGS_SVH
`define LID_REGS_SVH
// Register byte addresses
`define LID_A_CTRL    8'h00
`define LID_A_STATUS  8'h04
`define LID_A_IDS     8'h08
`define LID_A_FLAGS   8'h0c
`define LID_A_PATH    8'h10
`define LID_A_DLSIG   8'h14
`define LID_A_PIDS    8'h18
`define LID_A_GRANT   8'h1c
`define LID_A_VOL     8'h20
`define LID_A_RATE    8'h24
`define LID_A_EXPIRY  8'h28
`define LID_A_RAW     8'h80
// Control reset values; the tag value is arbitrary until software sets it
`define LID_TAG_RST   8'ha1
`define LID_EN_RST    1'b1
// Byte offsets behind the length byte
`define LID_O_GROUP   8'h00
`define LID_O_LOGON   8'h02
`define LID_O_FLAGS   8'h03
`define LID_O_MODE    8'h04
`define LID_O_PATH    8'h05
`define LID_O_CHAN    8'h07
`define LID_O_DLPATH  8'h09
`define LID_O_DLCHAN  8'h0b
// Capacity offsets relative to the end of the burst-specific part
`define LID_C_GRANT   8'h02
`define LID_C_VOL     8'h04
`define LID_C_RATE    8'h07
`define LID_C_EXPIRY  8'h09
// Body lengths of each layout
`define LID_N_ATMIP   8'h08
`define LID_N_ATM     8'h0c
`define LID_N_TS      8'h08
`define LID_N_CAP     8'h0a
// Default signalling pair replaced by the descriptor
`define LID_SIG_PATH  8'h00
`define LID_SIG_CHAN  16'h0005
`endif

// *** src/lid_pkg.sv ***
// Types shared by the logon descriptor parser modules.
// Assumes nothing beyond the compile order.
package lid_pkg;
    typedef enum logic [3:0] {
        LID_IDLE = 4'b0001,
        LID_LEN  = 4'b0010,
        LID_BODY = 4'b0100,
        LID_SKIP = 4'b1000
    } lid_state_e;
    typedef struct packed {
        logic [7:0]  terminal_a;
        logic [15:0] terminal_session_id;
        logic [8:0]  flags;
        logic [7:0]  uplink_path_id;
        logic [15:0] uplink_chan_id;
        logic [7:0]  downlink_sig_path_id;
        logic [15:0] downlink_sig_chan_id;
        logic [12:0] uplink_traffic_pid;
        logic [12:0] uplink_mgmt_pid;
        logic [23:0] fixed_rate_grant;
        logic [10:0] volume_req_limit;
        logic [23:0] rate_req_limit;
        logic [15:0] rate_req_expiry;
    } lid_fields_s;
endpackage

// *** src/lid_if.sv ***
// Body byte stream handed from the parser to its helpers.
// Assumes one clock shared by all ends.
`timescale 1ns/1ps
interface lid_if;
    logic [7:0] data;
    logic       valid;
    logic       clr;
    logic [4:0] idx;
    modport src (output data, output valid, output clr, output idx);
    modport snk (input data, input valid, input clr, input idx);
endinterface

// *** src/lid_acc.sv ***
// Shift register keeping the last three stream bytes, oldest on top.
// Assumes the byte stream interface on the parser clock.
`timescale 1ns/1ps
module lid_acc (
    input  wire logic  clk,
    input  wire logic  rst_n,
    lid_if.snk         bus,
    output logic [23:0] acc
);
    logic [23:0] next_acc;
    // Fields arrive most significant byte first
    always_comb begin
        next_acc = acc;
        if (bus.clr) begin
            next_acc = '0;
        end else if (bus.valid) begin
            next_acc = {acc[15:0], bus.data};
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end
endmodule // lid_acc

// *** src/lid_mem.sv ***
// Raw capture of the body bytes of accepted descriptors, at index modulo 32, for software read-back.
// Assumes the byte stream interface; read data is registered.
`timescale 1ns/1ps
module lid_mem (
    input  wire logic       clk,
    lid_if.snk              bus,
    input  wire logic [4:0] rd_addr,
    input  wire logic       rd_en,
    output logic [7:0]      rd_data
);
    logic [7:0] mem [0:31];
    // Write on body bytes, read one cycle after the strobe
    always_ff @(posedge clk) begin
        if (bus.valid) begin
            mem[bus.idx] <= bus.data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // lid_mem

// *** src/lid_parser.sv ***
// Logon descriptor parser: byte stream in, decoded fields in registers.
// Assumes bytes on SYS_CLK with DESC_START on the tag byte of a descriptor.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "lid_regs.svh"
module lid_parser (
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    input  wire logic [7:0]  DESC_BYTE,
    input  wire logic        DESC_VALID,
    input  wire logic        DESC_START,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA,
    output logic             PARSE_DONE,
    output logic             PARSE_ERR,
    output logic             PARSE_BUSY
);
    lid_pkg::lid_state_e  state, next_state;
    lid_pkg::lid_fields_s f, next_f;
    logic [7:0]  idx, next_idx, len, next_len, base, next_base;
    logic [7:0]  need, next_need;
    logic        hit, next_hit, short, next_short, mode_seen, next_mode_seen;
    logic        done, next_done, err, next_err;
    logic        en, next_en;
    logic [7:0]  tag_exp, next_tag_exp;
    logic [2:0]  sticky, next_sticky;
    logic [31:0] reg_q, next_reg_q;
    logic        raw_sel;
    logic        next_raw_sel, next_busy;
    logic [23:0] acc;
    logic [7:0]  mem_q, rel;
    logic [23:0] w;
    logic        body_byte, last;
    lid_if bus();

    ////////////////////////////////////////////////////////////////////////
    // Helpers: byte history and raw capture
    assign bus.data  = DESC_BYTE;
    assign bus.valid = DESC_VALID && (state == lid_pkg::LID_BODY);
    assign bus.clr   = DESC_VALID && DESC_START;
    assign bus.idx   = idx[4:0];
    lid_acc u_acc (
        .clk   (SYS_CLK),
        .rst_n (RESETN),
        .bus   (bus),
        .acc   (acc)
    );
    lid_mem u_mem (
        .clk     (SYS_CLK),
        .bus     (bus),
        .rd_addr (REG_ADDR[6:2]),
        .rd_en   (next_raw_sel),
        .rd_data (mem_q)
    );

    // Current word is the history with the arriving byte below it
    assign w         = {acc[15:0], DESC_BYTE};
    assign body_byte = DESC_VALID && !DESC_START;
    assign last      = (8'(idx + 8'h01) == len);
    assign rel       = 8'(idx - base);

    ////////////////////////////////////////////////////////////////////////
    // Descriptor walk and field extraction
    always_comb begin
        next_state     = state;
        next_idx       = idx;
        next_len       = len;
        next_base      = base;
        next_need      = need;
        next_hit       = hit;
        next_short     = short;
        next_mode_seen = mode_seen;
        next_done      = 1'b0;
        next_err       = 1'b0;
        next_f         = f;
        if (DESC_VALID && DESC_START) begin
            next_state     = lid_pkg::LID_LEN;
            next_hit       = en && (DESC_BYTE == tag_exp);
            next_short     = 1'b0;
            next_mode_seen = 1'b0;
        end else begin
            case (state)
            lid_pkg::LID_LEN: begin
                if (body_byte) begin
                    next_len = DESC_BYTE;
                    next_idx = '0;
                    if (DESC_BYTE == 8'h00) begin
                        next_state = lid_pkg::LID_IDLE;
                        next_err   = hit;
                    end else if (hit) begin
                        next_state = lid_pkg::LID_BODY;
                    end else begin
                        next_state = lid_pkg::LID_SKIP;
                    end
                end
            end
            lid_pkg::LID_BODY: begin
                if (body_byte) begin
                    next_idx = 8'(idx + 8'h01);
                    if (idx == `LID_O_GROUP) begin
                        next_f.terminal_a = DESC_BYTE;
                    end else if (idx == `LID_O_LOGON) begin
                        next_f.terminal_session_id = w[15:0];
                    end else if (idx == `LID_O_FLAGS) begin
                        // Two reserved bits on top are dropped
                        next_f.flags[8:3] = DESC_BYTE[5:0];
                    end else if (idx == `LID_O_MODE) begin
                        next_mode_seen = 1'b1;
                        // Bit 7 reserved; then capacity, burst, connectivity
                        next_f.flags[2] = DESC_BYTE[6];
                        next_f.flags[1] = DESC_BYTE[5];
                        next_f.flags[0] = !DESC_BYTE[5] && DESC_BYTE[4];
                        if (DESC_BYTE[5]) begin
                            next_base = `LID_N_TS;
                        end else if (DESC_BYTE[4]) begin
                            next_base = `LID_N_ATM;
                        end else begin
                            next_base = `LID_N_ATMIP;
                            next_f.downlink_sig_path_id = `LID_SIG_PATH;
                            next_f.downlink_sig_chan_id = `LID_SIG_CHAN;
                        end
                        next_need = DESC_BYTE[6] ? next_base
                                  : 8'(next_base + `LID_N_CAP);
                        next_short = (len < next_need);
                    end else if (idx == `LID_O_PATH) begin
                        if (f.flags[1]) begin
                            next_f.uplink_traffic_pid = w[12:0];
                        end else begin
                            // Four reserved bits came before this byte
                            next_f.uplink_path_id = DESC_BYTE;
                        end
                    end else if (idx == `LID_O_CHAN) begin
                        if (f.flags[1]) begin
                            next_f.uplink_mgmt_pid = w[12:0];
                        end else begin
                            next_f.uplink_chan_id = w[15:0];
                        end
                    end else if (idx == `LID_O_DLPATH && f.flags[0]) begin
                        next_f.downlink_sig_path_id = DESC_BYTE;
                    end else if (idx == `LID_O_DLCHAN && f.flags[0]) begin
                        next_f.downlink_sig_chan_id = w[15:0];
                    end
                    // Capacity limits follow the burst-specific part
                    if (mode_seen && !f.flags[2] && idx >= base) begin
                        if (rel == `LID_C_GRANT) begin
                            next_f.fixed_rate_grant = w;
                        end else if (rel == `LID_C_VOL) begin
                            next_f.volume_req_limit = w[10:0];
                        end else if (rel == `LID_C_RATE) begin
                            next_f.rate_req_limit = w;
                        end else if (rel == `LID_C_EXPIRY) begin
                            next_f.rate_req_expiry = w[15:0];
                        end
                    end
                    // Bytes past the layout are consumed until the length
                    if (last) begin
                        next_state = lid_pkg::LID_IDLE;
                        next_err   = short || !mode_seen || next_short;
                        next_done  = !next_err;
                    end
                end
            end
            lid_pkg::LID_SKIP: begin
                if (body_byte) begin
                    next_idx = 8'(idx + 8'h01);
                    if (last) begin
                        next_state = lid_pkg::LID_IDLE;
                    end
                end
            end
            default: begin
                next_state = lid_pkg::LID_IDLE;
            end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state     <= lid_pkg::LID_IDLE;
            idx       <= '0;
            len       <= '0;
            base      <= '0;
            need      <= '0;
            hit       <= 1'b0;
            short     <= 1'b0;
            mode_seen <= 1'b0;
            done      <= 1'b0;
            err       <= 1'b0;
            f         <= '0;
        end else begin
            state     <= next_state;
            idx       <= next_idx;
            len       <= next_len;
            base      <= next_base;
            need      <= next_need;
            hit       <= next_hit;
            short     <= next_short;
            mode_seen <= next_mode_seen;
            done      <= next_done;
            err       <= next_err;
            f         <= next_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port: control writes, status clear, registered reads
    always_comb begin
        next_en      = en;
        next_tag_exp = tag_exp;
        next_sticky  = sticky;
        next_reg_q   = '0;
        next_raw_sel = REG_RD && REG_ADDR >= `LID_A_RAW;
        next_busy    = next_state != lid_pkg::LID_IDLE;
        if (REG_WR && REG_ADDR == `LID_A_CTRL) begin
            next_en      = REG_WDATA[0];
            next_tag_exp = REG_WDATA[15:8];
        end else if (REG_WR && REG_ADDR == `LID_A_STATUS) begin
            next_sticky = sticky & ~REG_WDATA[2:0];
        end
        // Events set after the clear so a same-cycle event survives
        if (next_done) begin
            next_sticky[0] = 1'b1;
        end
        if (next_err) begin
            next_sticky[1] = 1'b1;
        end
        if (DESC_VALID && DESC_START && !next_hit) begin
            next_sticky[2] = 1'b1;
        end
        if (REG_ADDR == `LID_A_CTRL) begin
            next_reg_q = {16'h0000, tag_exp, 7'h00, en};
        end else if (REG_ADDR == `LID_A_STATUS) begin
            next_reg_q = {len, need, 11'h000, state != lid_pkg::LID_IDLE,
                          1'b0, sticky};
        end else if (REG_ADDR == `LID_A_IDS) begin
            next_reg_q = {8'h00, f.terminal_a, f.terminal_session_id};
        end else if (REG_ADDR == `LID_A_FLAGS) begin
            next_reg_q = {23'h000000, f.flags};
        end else if (REG_ADDR == `LID_A_PATH) begin
            next_reg_q = {8'h00, f.uplink_path_id, f.uplink_chan_id};
        end else if (REG_ADDR == `LID_A_DLSIG) begin
            next_reg_q = {8'h00, f.downlink_sig_path_id,
                          f.downlink_sig_chan_id};
        end else if (REG_ADDR == `LID_A_PIDS) begin
            next_reg_q = {3'h0, f.uplink_mgmt_pid, 3'h0, f.uplink_traffic_pid};
        end else if (REG_ADDR == `LID_A_GRANT) begin
            next_reg_q = {8'h00, f.fixed_rate_grant};
        end else if (REG_ADDR == `LID_A_VOL) begin
            next_reg_q = {21'h000000, f.volume_req_limit};
        end else if (REG_ADDR == `LID_A_RATE) begin
            next_reg_q = {8'h00, f.rate_req_limit};
        end else if (REG_ADDR == `LID_A_EXPIRY) begin
            next_reg_q = {16'h0000, f.rate_req_expiry};
        end
        // Read data only stands in the cycle after a read strobe
        if (!REG_RD) begin
            next_reg_q = '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            en         <= `LID_EN_RST;
            tag_exp    <= `LID_TAG_RST;
            sticky     <= '0;
            reg_q      <= '0;
            raw_sel    <= 1'b0;
            PARSE_BUSY <= 1'b0;
        end else begin
            en         <= next_en;
            tag_exp    <= next_tag_exp;
            sticky     <= next_sticky;
            reg_q      <= next_reg_q;
            raw_sel    <= next_raw_sel;
            PARSE_BUSY <= next_busy;
        end
    end
    assign REG_RDATA  = raw_sel ? {24'h000000, mem_q} : reg_q;
    assign PARSE_DONE = done;
    assign PARSE_ERR  = err;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    wire step = body_byte && state == lid_pkg::LID_BODY;
    tag_gate_a: assert property (DESC_VALID && DESC_START &&
        DESC_BYTE != tag_exp |=> !hit) else $error("wrong tag accepted");
    len_take_a: assert property (body_byte && state == lid_pkg::LID_LEN
        |=> len == $past(DESC_BYTE)) else $error("length not taken");
    group_a: assert property (step && idx == `LID_O_GROUP
        |=> f.terminal_a == $past(DESC_BYTE)) else $error("group wrong");
    session_a: assert property (step && idx == `LID_O_LOGON
        |=> f.terminal_session_id == {$past(acc[7:0]), $past(DESC_BYTE)})
        else $error("session id wrong");
    carrier_a: assert property (step && idx == `LID_O_FLAGS
        |=> f.flags[8] == $past(DESC_BYTE[5])) else $error("carrier wrong");
    ts_conn_a: assert property (step && idx == `LID_O_MODE &&
        DESC_BYTE[5] |=> !f.flags[0] ##1 !f.flags[0])
        else $error("connectivity set for stream bursts");
    short_a: assert property (step && last && short
        |=> PARSE_ERR && !PARSE_DONE) else $error("short length unflagged");
    pulse_a: assert property (PARSE_DONE |=> !PARSE_DONE)
        else $error("done longer than one cycle");
    busy_end_a: assert property (PARSE_DONE || PARSE_ERR
        |-> !PARSE_BUSY) else $error("busy after descriptor end");
    sig_dflt_a: assert property (step && idx == `LID_O_MODE &&
        DESC_BYTE[5:4] == 2'b00 |=> f.downlink_sig_chan_id == `LID_SIG_CHAN)
        else $error("default signalling pair not loaded");
    skip_end_a: assert property (state == lid_pkg::LID_SKIP &&
        body_byte && last |=> !PARSE_BUSY && !PARSE_DONE && !PARSE_ERR)
        else $error("skipped descriptor not ended quietly");
    grant_a: assert property (step && mode_seen && !f.flags[2] &&
        idx >= base && rel == `LID_C_GRANT |=> f.fixed_rate_grant ==
        {$past(acc[15:0]), $past(DESC_BYTE)}) else $error("grant wrong");
    cover property (PARSE_DONE && f.flags[1]);
    cover property (PARSE_DONE && f.flags[0] && !f.flags[2]);
    cover property (PARSE_ERR);
    cover property (PARSE_DONE && !f.flags[2] && !f.flags[1] && !f.flags[0]);
endmodule // lid_parser

// *** testbench/lid_ncc_model.sv ***
// Forward-link source model: sends descriptor bytes on the parser stream.
// Assumes the bench calls its tasks; bytes change just after rising edges.
`timescale 1ns/1ps
module lid_ncc_model (
    input  wire logic sys_clk,
    output logic [7:0] desc_byte,
    output logic       desc_valid,
    output logic       desc_start
);
    // Quiet stream at time zero
    initial begin
        desc_byte  = 8'h00;
        desc_valid = 1'b0;
        desc_start = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Idle cycles; the byte lane toggles so a stale byte never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            desc_valid <= 1'b0;
            desc_start <= 1'b0;
            desc_byte  <= ~desc_byte;
        end
    endtask
    // One byte, held until the next edge samples it
    task automatic put(input logic [7:0] b, input logic st);
        @(posedge sys_clk);
        desc_byte  <= b;
        desc_valid <= 1'b1;
        desc_start <= st;
    endtask
    // Tag, length, then len body bytes from the top, gap before byte 2
    task automatic send(input logic [7:0] tag, input logic [7:0] len,
                        input logic [255:0] body, input int gap);
        put(tag, 1'b1);
        put(len, 1'b0);
        for (int i = 0; i < len; i++) begin
            if (i == 2) idle(gap);
            put(body[255 - 8 * i -: 8], 1'b0);
        end
    endtask
endmodule // lid_ncc_model

// *** testbench/logon_init_descriptor_parser_tb.sv ***
// Self-checking bench for the logon descriptor parser.
// Assumes the source model drives the stream and this bench the registers.
`timescale 1ns/1ps
`include "lid_regs.svh"
module logon_init_descriptor_parser_tb;
    localparam logic [31:0] FULL = 32'hffffffff;
    logic         sys_clk;
    logic         resetn;
    logic [7:0]   desc_byte;
    logic         desc_valid;
    logic         desc_start;
    logic [7:0]   reg_addr;
    logic [31:0]  reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [31:0]  reg_rdata;
    logic         parse_done;
    logic         parse_err;
    logic         parse_busy;
    logic [255:0] body_a;
    logic [255:0] body_b;
    logic [255:0] body_c;
    int           bad_count = 0;
    int           total_checks = 0;
    int           done_seen = 0;

    lid_parser dut_u (
        .SYS_CLK    (sys_clk),
        .RESETN     (resetn),
        .DESC_BYTE  (desc_byte),
        .DESC_VALID (desc_valid),
        .DESC_START (desc_start),
        .REG_ADDR   (reg_addr),
        .REG_WDATA  (reg_wdata),
        .REG_WR     (reg_wr),
        .REG_RD     (reg_rd),
        .REG_RDATA  (reg_rdata),
        .PARSE_DONE (parse_done),
        .PARSE_ERR  (parse_err),
        .PARSE_BUSY (parse_busy)
    );
    lid_ncc_model partner_u (
        .sys_clk    (sys_clk),
        .desc_byte  (desc_byte),
        .desc_valid (desc_valid),
        .desc_start (desc_start)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Clock and count of completion pulses
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (parse_done === 1'b1) done_seen <= done_seen + 1;
    end
    // Verdict and end of run
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Register bus cycles; read data stands one cycle after the strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata & m, exp);
    endtask
    // Outcome {err, done} of the descriptor just sent, bounded wait
    task automatic ends(input logic [1:0] exp);
        logic [1:0] r;
        r = 2'b00;
        @(negedge sys_clk);
        chk({31'h0, parse_busy}, 32'h1);
        partner_u.idle(1);
        for (int i = 0; i < 4 && r == 2'b00; i++) begin
            @(negedge sys_clk);
            r = {parse_err, parse_done};
        end
        chk({30'h0, r}, {30'h0, exp});
        chk({31'h0, parse_busy}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung stream or bus
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end
    // Main sequence; reserved bits differ in every body
    initial begin
        resetn    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        body_a = {8'h5a, 16'hc3e1, 2'b10, 6'b101101, 4'b1000, 4'hb, 8'h9c,
                  16'h1234, 24'hfedcba, 5'h15, 11'h5a5, 24'h123456,
                  16'h0000, 16'hdead, 96'h0};
        body_b = {8'h01, 16'h0203, 2'b01, 6'b010010, 4'b0101, 4'h6, 8'h77,
                  16'hbeef, 8'h3c, 8'h44, 16'h0a0b, 160'h0};
        body_c = {8'hff, 16'h8001, 2'b11, 6'b000000, 3'b001, 13'h1abc,
                  3'b101, 13'h0f0f, 24'h000001, 5'h0a, 11'h7ff,
                  24'hffffff, 16'hffff, 112'h0};
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`LID_A_CTRL, FULL, 32'h0000a101);
        rd(`LID_A_STATUS, FULL, 32'h0);
        wr(8'h40, FULL);
        rd(8'h40, FULL, 32'h0);
        // ATM burst, IP connectivity, limits, two trailing bytes, a gap
        partner_u.send(8'ha1, 8'd20, body_a, 3);
        ends(2'b01);
        rd(`LID_A_IDS, FULL, 32'h005ac3e1);
        rd(`LID_A_FLAGS, FULL, 32'h00000168);
        rd(`LID_A_PATH, FULL, 32'h009c1234);
        rd(`LID_A_DLSIG, FULL, 32'h00000005);
        rd(`LID_A_GRANT, FULL, 32'h00fedcba);
        rd(`LID_A_VOL, FULL, 32'h000005a5);
        rd(`LID_A_RATE, FULL, 32'h00123456);
        rd(`LID_A_EXPIRY, FULL, 32'h0);
        for (int n = 0; n < 20; n++) begin
            rd(`LID_A_RAW + 8'(4 * n), 32'hff,
               32'(body_a[255-8*n -: 8]));
        end
        // ATM connectivity, no limits, exact length
        partner_u.send(8'ha1, 8'd12, body_b, 0);
        ends(2'b01);
        rd(`LID_A_FLAGS, FULL, 32'h00000095);
        rd(`LID_A_PATH, FULL, 32'h0077beef);
        rd(`LID_A_DLSIG, FULL, 32'h00440a0b);
        // Back to back: ATM-IP then transport stream with limits
        partner_u.send(8'ha1, 8'd20, body_a, 0);
        partner_u.send(8'ha1, 8'd18, body_c, 0);
        ends(2'b01);
        rd(`LID_A_FLAGS, FULL, 32'h00000002);
        rd(`LID_A_PIDS, FULL, 32'h0f0f1abc);
        rd(`LID_A_GRANT, FULL, 32'h00000001);
        rd(`LID_A_VOL, FULL, 32'h000007ff);
        rd(`LID_A_RATE, FULL, 32'h00ffffff);
        rd(`LID_A_EXPIRY, FULL, 32'h0000ffff);
        chk(32'(done_seen), 32'd4);
        // Too short for the layout, then an empty descriptor
        wr(`LID_A_STATUS, 32'h7);
        partner_u.send(8'ha1, 8'd10, body_c, 1);
        ends(2'b10);
        rd(`LID_A_STATUS, 32'hffff0017, 32'h0a120002);
        wr(`LID_A_STATUS, 32'h2);
        rd(`LID_A_STATUS, 32'h17, 32'h0);
        partner_u.send(8'ha1, 8'd0, body_c, 0);
        ends(2'b10);
        // Parser off, then a foreign tag, then the new tag
        wr(`LID_A_CTRL, 32'h00003c00);
        partner_u.send(8'h3c, 8'd20, body_a, 0);
        ends(2'b00);
        wr(`LID_A_CTRL, 32'h00003c01);
        rd(`LID_A_CTRL, FULL, 32'h00003c01);
        wr(`LID_A_STATUS, 32'h4);
        partner_u.send(8'ha1, 8'd20, body_a, 0);
        ends(2'b00);
        rd(`LID_A_STATUS, 32'h4, 32'h4);
        partner_u.send(8'h3c, 8'd12, body_b, 2);
        ends(2'b01);
        rd(`LID_A_IDS, FULL, 32'h00010203);
        summarize();
    end
endmodule // logon_init_descriptor_parser_tb
